// [pkg/gdio_pkg.sv]
package gdio_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned PORT_W   = 8;
    localparam int unsigned APB_AW   = 12;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_INPUT_SAMPLE = 12'h000;
    localparam logic [11:0] OFS_DIRECTION    = 12'h004;
    localparam logic [11:0] OFS_OUTPUT_VALUE = 12'h008;
    localparam logic [11:0] OFS_MCU_CONTROL  = 12'h00C;
    localparam logic [11:0] OFS_SLEEP_CTRL   = 12'h010;
    localparam logic [11:0] OFS_EXTINT_CTRL  = 12'h014;
    localparam logic [11:0] OFS_EXTINT_FLAG  = 12'h018;

    // ==========================================================
    // Field positions
    localparam int unsigned PULLUP_DIS_BIT = 4;
    localparam int unsigned SLEEP_EN_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  RST_PORT     = 8'h00;
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [2:0]  RST_SLEEP    = 3'h0;
    localparam logic [15:0] RST_SENSE    = 16'h0000;

    // ==========================================================
    // External interrupt sense encodings (two bits per pin)
    typedef enum logic [1:0] {
        GDIO_SENSE_LOW  = 2'b00,
        GDIO_SENSE_ANY  = 2'b01,
        GDIO_SENSE_FALL = 2'b10,
        GDIO_SENSE_RISE = 2'b11
    } gdio_sense_e;

    // ==========================================================
    // Sleep mode encodings
    localparam logic [2:0] SLEEP_IDLE      = 3'h0;
    localparam logic [2:0] SLEEP_ADC_NR    = 3'h1;
    localparam logic [2:0] SLEEP_PWR_DOWN  = 3'h2;
    localparam logic [2:0] SLEEP_PWR_SAVE  = 3'h3;
    localparam logic [2:0] SLEEP_STANDBY   = 3'h6;
    localparam logic [2:0] SLEEP_EXT_STBY  = 3'h7;

endpackage

// [rtl/gdio_sync_bit.sv]
`timescale 1ns/1ps

// ==========================================================
// One-pin input synchronizer: latch open on clock high, then flop
module gdio_sync_bit (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    input  wire logic pad_level,
    output logic      sample_q
);

    logic latch_q;

    // Transparent while clock high, holds while low
    always_latch begin
        if (sys_clk) begin
            latch_q = pad_level;
        end
    end

    // Held value loads at next rising edge
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= latch_q;
        end
    end

endmodule

// [rtl/gdio_port.sv]
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module gdio_port (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pads
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe_n,
    output logic      [7:0]  pad_pullup_en,
    // Sleep request from the system
    input  wire logic        sleep_active
);

    // ==========================================================
    // State
    logic [7:0] port_direction_reg_q;
    logic [7:0] port_output_value_reg_q;
    logic [7:0] port_input_sample_reg;
    logic [7:0] mcu_control_reg_q;
    logic [2:0] sleep_mode_q;
    logic [7:0] extint_enable_q;
    logic [15:0] extint_sense_q;
    logic [7:0] extint_flag_q;
    logic [7:0] clamped_prev_q;
    logic [31:0] prdata_q;

    logic       global_pullup_disable;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic       clamp_sleep;
    logic [7:0] clamp_pin;
    logic [7:0] digital_in;
    logic [7:0] edge_hit;
    logic [7:0] flag_clr;

    // ==========================================================
    // Helpers
    function automatic logic gdio_mapped(input logic [11:0] a);
        gdio_mapped = (a == gdio_pkg::OFS_INPUT_SAMPLE) ||
                      (a == gdio_pkg::OFS_DIRECTION)    ||
                      (a == gdio_pkg::OFS_OUTPUT_VALUE) ||
                      (a == gdio_pkg::OFS_MCU_CONTROL)  ||
                      (a == gdio_pkg::OFS_SLEEP_CTRL)   ||
                      (a == gdio_pkg::OFS_EXTINT_CTRL)  ||
                      (a == gdio_pkg::OFS_EXTINT_FLAG);
    endfunction

    function automatic logic gdio_deep_sleep(input logic [2:0] m);
        gdio_deep_sleep = (m == gdio_pkg::SLEEP_PWR_DOWN) ||
                          (m == gdio_pkg::SLEEP_PWR_SAVE) ||
                          (m == gdio_pkg::SLEEP_STANDBY)  ||
                          (m == gdio_pkg::SLEEP_EXT_STBY);
    endfunction

    // ==========================================================
    // Bus decode; zero-wait slave, unmapped gives pslverr
    // Writes land in the access cycle, reads are captured in the
    // setup cycle so prdata comes straight from a flop; the cost
    // is that a read sees state one edge older than the access.
    assign addr_ok = gdio_mapped(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign prdata  = prdata_q;

    // Shared by every pin of every port
    assign global_pullup_disable = mcu_control_reg_q[gdio_pkg::PULLUP_DIS_BIT];

    // ==========================================================
    // Port registers

    // Direction register
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            port_direction_reg_q <= gdio_pkg::RST_PORT;
        end else if (wr_en && paddr == gdio_pkg::OFS_DIRECTION) begin
            port_direction_reg_q <= pwdata[7:0];
        end
    end

    // Output value register; write to input reg toggles ones
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            port_output_value_reg_q <= gdio_pkg::RST_PORT;
        end else if (wr_en && paddr == gdio_pkg::OFS_OUTPUT_VALUE) begin
            port_output_value_reg_q <= pwdata[7:0];
        end else if (wr_en && paddr == gdio_pkg::OFS_INPUT_SAMPLE) begin
            port_output_value_reg_q <= port_output_value_reg_q ^ pwdata[7:0];
        end
    end

    // ==========================================================
    // Control registers, one process per concern

    // Global pull-up disable lives in the mcu control word
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mcu_control_reg_q <= gdio_pkg::RST_PORT;
        end else if (wr_en && paddr == gdio_pkg::OFS_MCU_CONTROL) begin
            mcu_control_reg_q <= pwdata[7:0];
        end
    end

    // Sleep mode field; only the clamping modes matter here
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sleep_mode_q <= gdio_pkg::RST_SLEEP;
        end else if (wr_en && paddr == gdio_pkg::OFS_SLEEP_CTRL) begin
            sleep_mode_q <= pwdata[3:1];
        end
    end

    // Interrupt enables pick the pins that skip the sleep clamp
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            extint_enable_q <= gdio_pkg::RST_PORT;
        end else if (wr_en && paddr == gdio_pkg::OFS_EXTINT_CTRL) begin
            extint_enable_q <= pwdata[7:0];
        end
    end

    // Sense codes, two bits per pin; kept apart from the enables
    // because edge detection runs even with the request disabled
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            extint_sense_q <= gdio_pkg::RST_SENSE;
        end else if (wr_en && paddr == gdio_pkg::OFS_EXTINT_CTRL) begin
            extint_sense_q <= pwdata[31:16];
        end
    end

    // ==========================================================
    // Pad drive; during reset direction is zero so pins float
    // Reset gates the enables directly, so the pins let go at
    // once, before any clock edge has cleared the registers.
    // The pull-up is only on for direction 0, value 1 and the
    // global disable clear; drivers and pull-up never fight.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_oe_n[i] = !(reset_n && port_direction_reg_q[i]);
            pad_out[i]  = port_output_value_reg_q[i];
            pad_pullup_en[i] = reset_n && !port_direction_reg_q[i] &&
                               port_output_value_reg_q[i] &&
                               !global_pullup_disable;
        end
    end

    // ==========================================================
    // Sleep clamp ahead of synchronizer, bypassed for enabled pins
    assign clamp_sleep = sleep_active && gdio_deep_sleep(sleep_mode_q);
    assign clamp_pin   = {8{clamp_sleep}} & ~extint_enable_q;
    assign digital_in  = pad_in & ~clamp_pin;

    // Synchronizers sample pad level for any direction
    // A driven pin is read back too, which lets software see a
    // shorted or overloaded output.
    generate
        for (genvar g = 0; g < 8; g++) begin : g_sync
            gdio_sync_bit u_sync (
                .sys_clk   (sys_clk),
                .reset_n   (reset_n),
                .pad_level (digital_in[g]),
                .sample_q  (port_input_sample_reg[g])
            );
        end
    endgenerate

    // ==========================================================
    // External interrupt edge detection on synchronized input;
    // the clamp lifting on a held-high pin looks like a rising edge
    // Sense code low-level never raises a flag here; it is the
    // reset code, so no edge is reported while pins settle.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            case (gdio_pkg::gdio_sense_e'(extint_sense_q[2*i +: 2]))
                gdio_pkg::GDIO_SENSE_ANY: begin
                    edge_hit[i] = port_input_sample_reg[i] ^ clamped_prev_q[i];
                end
                gdio_pkg::GDIO_SENSE_FALL: begin
                    edge_hit[i] = clamped_prev_q[i] && !port_input_sample_reg[i];
                end
                gdio_pkg::GDIO_SENSE_RISE: begin
                    edge_hit[i] = !clamped_prev_q[i] && port_input_sample_reg[i];
                end
                default: begin
                    edge_hit[i] = 1'b0;
                end
            endcase
        end
    end

    // Previous synchronized level, one per pin
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            clamped_prev_q <= gdio_pkg::RST_PORT;
        end else begin
            clamped_prev_q <= port_input_sample_reg;
        end
    end

    // Clear mask only during a flag write
    assign flag_clr = (wr_en && paddr == gdio_pkg::OFS_EXTINT_FLAG) ? pwdata[7:0] : 8'h00;

    // Flag set wins over write-one-to-clear, so an edge that
    // lands with a late clear is never lost
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            extint_flag_q <= gdio_pkg::RST_PORT;
        end else begin
            extint_flag_q <= (extint_flag_q & ~flag_clr) | edge_hit;
        end
    end

    // ==========================================================
    // Read data registered in setup phase, valid in access phase
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prdata_q <= gdio_pkg::RST_WORD;
        end else if (rd_en) begin
            // Unmapped offsets read zero alongside pslverr
            case (paddr)
                gdio_pkg::OFS_INPUT_SAMPLE: begin
                    prdata_q <= {24'h00_0000, port_input_sample_reg};
                end
                gdio_pkg::OFS_DIRECTION: begin
                    prdata_q <= {24'h00_0000, port_direction_reg_q};
                end
                gdio_pkg::OFS_OUTPUT_VALUE: begin
                    prdata_q <= {24'h00_0000, port_output_value_reg_q};
                end
                gdio_pkg::OFS_MCU_CONTROL: begin
                    prdata_q <= {24'h00_0000, mcu_control_reg_q};
                end
                gdio_pkg::OFS_SLEEP_CTRL: begin
                    prdata_q <= {28'h000_0000, sleep_mode_q, 1'b0};
                end
                gdio_pkg::OFS_EXTINT_CTRL: begin
                    prdata_q <= {extint_sense_q, 8'h00, extint_enable_q};
                end
                gdio_pkg::OFS_EXTINT_FLAG: begin
                    prdata_q <= {24'h00_0000, extint_flag_q};
                end
                default: begin
                    prdata_q <= gdio_pkg::RST_WORD;
                end
            endcase
        end
    end

endmodule

// [test/gdio_pad_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Pad side: device drive, outside driver, pull-up, else floating
module gdio_pad_model (
    input  wire logic       sys_clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe_n,
    input  wire logic [7:0] pad_pullup_en,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad_in
);
    logic [7:0] flt_q = 8'h00;
    // Floating lines wander, so a stale level never passes
    always_ff @(posedge sys_clk) flt_q <= ~flt_q;
    // Priority per pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
            else pad_in[i] = flt_q[i];
        end
    end
endmodule

// [test/gdio_port_chk.sv]
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the pin block
module gdio_port_chk (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  pad_in,
    input wire logic [7:0]  pad_out,
    input wire logic [7:0]  pad_oe_n,
    input wire logic [7:0]  pad_pullup_en,
    input wire logic        sleep_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Access phase and mapped-address helpers
    logic acc, map;
    assign acc = psel && penable;
    assign map = (paddr <= 12'h018) && (paddr[1:0] == 2'b00);
    property p_dir;
        acc && pwrite && paddr == gdio_pkg::OFS_DIRECTION |=> pad_oe_n == ~$past(pwdata[7:0]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("direction not applied");
    property p_tgl;
        acc && pwrite && paddr == gdio_pkg::OFS_INPUT_SAMPLE
        |=> pad_out == ($past(pad_out) ^ $past(pwdata[7:0]));
    endproperty
    a_tgl: assert property (p_tgl)
        else $error("toggle wrong");
    property p_hold;
        !(acc && pwrite && (paddr == 12'h000 || paddr == 12'h008)) |=> $stable(pad_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("output value moved");
    property p_pu;
        (pad_pullup_en & ~(pad_oe_n & pad_out)) == 8'h00;
    endproperty
    a_pu: assert property (p_pu)
        else $error("pull-up on wrong pin");
    property p_rst;
        disable iff (1'b0) !reset_n |-> pad_oe_n == 8'hFF && pad_pullup_en == 8'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset pins");
    property p_err;
        acc && !map |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped not refused");
    property p_up;
        acc && !pwrite && paddr <= 12'h008 |-> prdata[31:8] == 24'h0;
    endproperty
    a_up: assert property (p_up)
        else $error("upper bits set");
    property p_smp;
        acc && !pwrite && paddr == 12'h000 && $stable(pad_in)
        && pad_in == $past(pad_in, 2) && pad_in == $past(pad_in, 3) && !sleep_active
        && !$past(sleep_active, 3) |-> prdata[7:0] == pad_in;
    endproperty
    a_smp: assert property (p_smp)
        else $error("sample wrong");
    property p_rdy;
        pready;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("pready low");
endmodule

bind gdio_port gdio_port_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en), .sleep_active(sleep_active));

// [test/gdio_port_test.sv]
`timescale 1ns/1ps
// ==========================================================
// Bench for the pin block
module gdio_port_test;
    localparam logic [11:0] A_IN = gdio_pkg::OFS_INPUT_SAMPLE;
    localparam logic [11:0] A_DIR = gdio_pkg::OFS_DIRECTION;
    localparam logic [11:0] A_OUT = gdio_pkg::OFS_OUTPUT_VALUE;
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err_q, sleep_active = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup_en, ext_en = 8'hFF, ext_val = 8'h00;
    int          fail_count = 0, n_tests = 0;
    // Clock
    always #50 sys_clk = ~sys_clk;
    gdio_port uut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .sleep_active(sleep_active));
    gdio_pad_model u_pad (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup_en(pad_pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One idle cycle always precedes the setup phase, so readback is never too early
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic nap(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_pins;
        rdc(A_DIR, 32'h0);
        rdc(A_OUT, 32'h0);
        rdc(A_IN, 32'h0);
        ext_en <= 8'h00;
        wr(A_OUT, 32'hFF);
        nap(1);
        chk({24'h0, pad_pullup_en}, 32'hFF);
        rdc(A_IN, 32'hFF);
        wr(A_DIR, 32'hFF);
        nap(1);
        chk({pad_oe_n, pad_pullup_en}, 32'h0);
        wr(A_IN, 32'h0F);
        wr(A_IN, 32'h00);
        nap(1);
        chk({24'h0, pad_out}, 32'hF0);
        rdc(A_IN, 32'hF0);
        wr(A_DIR, 32'h00);
        nap(1);
        chk({24'h0, pad_pullup_en}, 32'hF0);
        wr(gdio_pkg::OFS_MCU_CONTROL, 32'h10);
        wr(A_IN, 32'h0F);
        nap(1);
        chk({pad_out, pad_pullup_en}, 32'hFF00);
        wr(gdio_pkg::OFS_MCU_CONTROL, 32'h0);
        nap(1);
        chk({24'h0, pad_pullup_en}, 32'hFF);
        $display("test pins done");
    endtask
    task automatic t_sleep;
        logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        wr(gdio_pkg::OFS_EXTINT_CTRL, 32'h000C_0000);
        wr(gdio_pkg::OFS_SLEEP_CTRL, 32'h5);
        sleep_active <= 1'b1;
        nap(3);
        rdc(A_IN, 32'h0);
        wr(gdio_pkg::OFS_EXTINT_FLAG, 32'hFF);
        sleep_active <= 1'b0;
        nap(4);
        apb(1'b0, gdio_pkg::OFS_EXTINT_FLAG, 32'h0);
        chk(rd & 32'h2, 32'h2);
        wr(gdio_pkg::OFS_EXTINT_CTRL, 32'h1);
        sleep_active <= 1'b1;
        nap(3);
        rdc(A_IN, 32'h01);
        wr(gdio_pkg::OFS_EXTINT_CTRL, 32'h0);
        foreach (m[i]) begin
            wr(gdio_pkg::OFS_SLEEP_CTRL, {28'h0, m[i], 1'b1});
            nap(3);
            rdc(A_IN, (m[i] inside {3'h2, 3'h3, 3'h6, 3'h7}) ? 32'h0 : 32'hFF);
        end
        sleep_active <= 1'b0;
        $display("test sleep done");
    endtask
    task automatic t_err_rst;
        apb(1'b0, 12'h01C, 32'h0);
        chk({err_q, rd[30:0]}, 32'h8000_0000);
        wr(A_DIR, 32'h0F);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        #1;
        chk({pad_oe_n, pad_pullup_en}, 32'hFF00);
        nap(2);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        rdc(A_DIR, 32'h0);
        $display("test error and reset done");
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_pins();
        t_sleep();
        t_err_rst();
        close_out();
    end
    // Watchdog, far beyond the roughly 160 cycles the tests need
    initial begin
        #3_000_000;
        fail_count++;
        close_out();
    end
endmodule
